//--- ispm_cfg.svh
/*
 * Constants of the interrupt source priority map: register offsets,
 * reset values, priority field positions and event codes.
 * Assumes inclusion by the package and by the core module.
 */
`ifndef ISPM_CFG_SVH
`define ISPM_CFG_SVH

// ************************************************************
// Register offsets (byte addresses)
// ************************************************************
`define ISPM_OFS_PRIO_A   8'h00
`define ISPM_OFS_PRIO_B   8'h04
`define ISPM_OFS_PRIO_C   8'h08
`define ISPM_OFS_PRIO_D   8'h0C
`define ISPM_OFS_CTRL     8'h10
`define ISPM_OFS_EVCODE   8'h14
`define ISPM_OFS_STATUS   8'h18
`define ISPM_OFS_MASK     8'h1C

// ************************************************************
// Reset values and writable bits
// ************************************************************
`define ISPM_RST_PRIO_ABC 16'h0000
`define ISPM_RST_PRIO_D   16'hDA74
`define ISPM_WMASK_A      16'hFFFF
`define ISPM_WMASK_B      16'hF0F0
`define ISPM_WMASK_C      16'h00FF
`define ISPM_PINMODE_BIT  7
`define ISPM_ST_ACCEPT    0
`define ISPM_ST_SPURIOUS  1

// ************************************************************
// Priority field low bit positions
// ************************************************************
`define ISPM_FLD_HI       12
`define ISPM_FLD_MH       8
`define ISPM_FLD_ML       4
`define ISPM_FLD_LO       0

// ************************************************************
// Event codes
// ************************************************************
`define ISPM_EV_ENC_BASE  12'h200
`define ISPM_EV_ENC_STEP  12'h020
`define ISPM_LVL_TOP      4'hF
`define ISPM_EV_PIN0      12'h240
`define ISPM_EV_PIN1      12'h2A0
`define ISPM_EV_PIN2      12'h300
`define ISPM_EV_PIN3      12'h360
`define ISPM_EV_DEBUG     12'h600
`define ISPM_EV_TMR0      12'h400
`define ISPM_EV_TMR1      12'h420
`define ISPM_EV_TMR2_UNF  12'h440
`define ISPM_EV_TMR2_CAP  12'h460
`define ISPM_EV_ALARM     12'h480
`define ISPM_EV_PERIODIC  12'h4A0
`define ISPM_EV_CARRY     12'h4C0
`define ISPM_EV_SP1_BASE  12'h4E0
`define ISPM_EV_SP2_BASE  12'h700
`define ISPM_EV_WDOG      12'h560

`endif

//--- ispm_pkg.sv
/*
 * Types of the interrupt source priority map.
 * Assumes the constants header is on the include path.
 */
package ispm_pkg;
	`include "ispm_cfg.svh"

	// Serial port requests, highest ranked first
	typedef struct packed {
		logic rxError;
		logic rxFull;
		logic lineBreak;
		logic txEmpty;
	} ispm_serial_t;

	typedef struct packed {
		logic         debugPort;
		logic         timer0Unf;
		logic         timer1Unf;
		logic         timer2Unf;
		logic         timer2Cap;
		logic         clockAlarm;
		logic         clockPeriodic;
		logic         clockCarry;
		ispm_serial_t serial1;
		ispm_serial_t serial2;
		logic         watchdogInterval;
	} ispm_periph_t;

	typedef struct packed {
		logic        valid;
		logic [3:0]  level;
		logic [11:0] code;
	} ispm_req_t;
endpackage

//--- ispm_core.sv
/*
 * Interrupt source priority map: maps request pins and on-chip peripheral
 * requests to event codes and levels, picks the winner, and offers it to
 * the core. Registers reached over AXI4-Lite.
 * Assumes peripheral requests and coreAck are on sys_clk; request pins
 * are asynchronous.
 */
// What this block does
// [R01] Encoded pin levels 5..1 give codes 0x340..0x3C0 at their own level.
// [R02] Independent pin 0 gives code 0x240, level from register D bits 15:12.
// [R03] Independent pin 1 gives code 0x2A0, level from register D bits 11:8.
// [R04] Independent pin 2 gives code 0x300, level from register D bits 7:4.
// [R05] Independent pin 3 gives code 0x360, level from register D bits 3:0.
// [R06] Debug port gives code 0x600, level from register C bits 3:0.
// [R07] Timer 0 underflow gives code 0x400, level from register A bits 15:12.
// [R08] Timer 1 underflow gives code 0x420, level from register A bits 11:8.
// [R09] Timer 2 underflow 0x440 beats capture 0x460, both register A 7:4.
// [R10] Clock alarm, periodic, carry share register A 3:0, in that rank.
// [R11] Serial 1 error, full, break, empty share register B 7:4, ranked so.
// [R12] Serial 2 error, full, break, empty share register C 7:4, ranked so.
// [R13] Watchdog interval gives code 0x560, level from register B 15:12.
// [R14] Accepted source code is placed in the event code register.
// [R15] Equal levels are served in the fixed default ranking order.
// [R16] Field zero masks its sources; 0xF is level 15.
// [R17] Pin mode bit 1 makes four independent pins, else one encoded level.
// [R18] Only the best pending unmasked request goes out, reselected every cycle.
`timescale 1ns/1ns
`include "ispm_cfg.svh"
module ispm_core
	import ispm_pkg::*;
(
	input  wire logic                sys_clk,
	input  wire logic                reset_n,
	input  wire logic [7:0]          s_axi_awaddr,
	input  wire logic                s_axi_awvalid,
	output logic                     s_axi_awready,
	input  wire logic [31:0]         s_axi_wdata,
	input  wire logic [3:0]          s_axi_wstrb,
	input  wire logic                s_axi_wvalid,
	output logic                     s_axi_wready,
	output logic [1:0]               s_axi_bresp,
	output logic                     s_axi_bvalid,
	input  wire logic                s_axi_bready,
	input  wire logic [7:0]          s_axi_araddr,
	input  wire logic                s_axi_arvalid,
	output logic                     s_axi_arready,
	output logic [31:0]              s_axi_rdata,
	output logic [1:0]               s_axi_rresp,
	output logic                     s_axi_rvalid,
	input  wire logic                s_axi_rready,
	input  wire logic [3:0]          levelRequestPins,
	input  wire ispm_pkg::ispm_periph_t periphIrq,
	input  wire logic                coreAck,
	output ispm_pkg::ispm_req_t      coreReq,
	output logic                     irqOut
);
	import ispm_pkg::*;
	localparam int NSRC = 22;

	// ************************************************************
	// Helpers
	// ************************************************************
	function automatic logic [3:0] fieldOf(input logic [15:0] r, input int lsb);
		fieldOf = r[lsb +: 4];
	endfunction

	function automatic logic [11:0] encCode(input logic [3:0] lvl);
		logic [11:0] steps;
		steps = {8'h00, `ISPM_LVL_TOP - lvl};
		encCode = `ISPM_EV_ENC_BASE + 12'(steps * `ISPM_EV_ENC_STEP);
	endfunction

	// ************************************************************
	// State
	// ************************************************************
	logic [15:0] priorityRegA_r, priorityRegB_r, priorityRegC_r, priorityRegD_r;
	logic        pinModeSelect_r;
	logic [11:0] eventCodeRegister_r;
	logic [1:0]  status_r, statusSet, statusClr;
	logic [1:0]  mask_r;
	logic [3:0]  pinsS1_r, pinsS2_r;
	ispm_req_t   coreReq_r;
	ispm_req_t   coreReq_nxt;
	logic        irqOut_r;
	logic [7:0]  awAddr_r;
	logic        awReady_r;
	logic [31:0] wData_r;
	logic [3:0]  wStrb_r;
	logic        wReady_r;
	logic        bValid_r;
	logic [1:0]  bResp_r;
	logic        rValid_r, arReady_r;
	logic [31:0] rData_r;
	logic [1:0]  rResp_r;
	logic        doWrite;
	logic        wrHit;
	logic [3:0]  srcLvl [NSRC];
	logic [11:0] srcCode [NSRC];
	logic [NSRC-1:0] srcAct;

	// ************************************************************
	// Pin synchroniser
	// ************************************************************
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			pinsS1_r <= 4'h0;
			pinsS2_r <= 4'h0;
		end else begin
			pinsS1_r <= levelRequestPins;
			pinsS2_r <= pinsS1_r;
		end
	end

	// ************************************************************
	// Source table, listed in default ranking order
	// ************************************************************
	always_comb begin
		for (int i = 0; i < NSRC; i++) begin
			srcLvl[i]  = 4'h0;
			srcCode[i] = 12'h000;
			srcAct[i]  = 1'b0;
		end
		// Encoded level: code and level follow the pins themselves
		srcLvl[0]  = pinsS2_r;                                               // [R01]
		srcCode[0] = encCode(pinsS2_r);                                      // [R01]
		srcAct[0]  = !pinModeSelect_r && (pinsS2_r != 4'h0);                 // [R17]
		srcLvl[1]  = fieldOf(priorityRegD_r, `ISPM_FLD_HI);                  // [R02]
		srcCode[1] = `ISPM_EV_PIN0;                                          // [R02]
		srcLvl[2]  = fieldOf(priorityRegD_r, `ISPM_FLD_MH);                  // [R03]
		srcCode[2] = `ISPM_EV_PIN1;                                          // [R03]
		srcLvl[3]  = fieldOf(priorityRegD_r, `ISPM_FLD_ML);                  // [R04]
		srcCode[3] = `ISPM_EV_PIN2;                                          // [R04]
		srcLvl[4]  = fieldOf(priorityRegD_r, `ISPM_FLD_LO);                  // [R05]
		srcCode[4] = `ISPM_EV_PIN3;                                          // [R05]
		for (int p = 0; p < 4; p++) begin
			srcAct[1+p] = pinModeSelect_r && pinsS2_r[p];                    // [R17]
		end
		srcLvl[5]  = fieldOf(priorityRegC_r, `ISPM_FLD_LO);                  // [R06]
		srcCode[5] = `ISPM_EV_DEBUG;                                         // [R06]
		srcAct[5]  = periphIrq.debugPort;
		srcLvl[6]  = fieldOf(priorityRegA_r, `ISPM_FLD_HI);                  // [R07]
		srcCode[6] = `ISPM_EV_TMR0;                                          // [R07]
		srcAct[6]  = periphIrq.timer0Unf;
		srcLvl[7]  = fieldOf(priorityRegA_r, `ISPM_FLD_MH);                  // [R08]
		srcCode[7] = `ISPM_EV_TMR1;                                          // [R08]
		srcAct[7]  = periphIrq.timer1Unf;
		srcLvl[8]  = fieldOf(priorityRegA_r, `ISPM_FLD_ML);                  // [R09]
		srcCode[8] = `ISPM_EV_TMR2_UNF;                                      // [R09]
		srcAct[8]  = periphIrq.timer2Unf;
		srcLvl[9]  = fieldOf(priorityRegA_r, `ISPM_FLD_ML);                  // [R09]
		srcCode[9] = `ISPM_EV_TMR2_CAP;                                      // [R09]
		srcAct[9]  = periphIrq.timer2Cap;
		srcLvl[10]  = fieldOf(priorityRegA_r, `ISPM_FLD_LO);                 // [R10]
		srcCode[10] = `ISPM_EV_ALARM;                                        // [R10]
		srcAct[10]  = periphIrq.clockAlarm;
		srcLvl[11]  = fieldOf(priorityRegA_r, `ISPM_FLD_LO);                 // [R10]
		srcCode[11] = `ISPM_EV_PERIODIC;                                     // [R10]
		srcAct[11]  = periphIrq.clockPeriodic;
		srcLvl[12]  = fieldOf(priorityRegA_r, `ISPM_FLD_LO);                 // [R10]
		srcCode[12] = `ISPM_EV_CARRY;                                        // [R10]
		srcAct[12]  = periphIrq.clockCarry;
		// Serial sources sit one code step apart, error first
		for (int s = 0; s < 4; s++) begin
			srcLvl[13+s]  = fieldOf(priorityRegB_r, `ISPM_FLD_ML);           // [R11]
			srcCode[13+s] = `ISPM_EV_SP1_BASE + 12'(s * `ISPM_EV_ENC_STEP);  // [R11]
			srcAct[13+s]  = periphIrq.serial1[3-s];
			srcLvl[17+s]  = fieldOf(priorityRegC_r, `ISPM_FLD_ML);           // [R12]
			srcCode[17+s] = `ISPM_EV_SP2_BASE + 12'(s * `ISPM_EV_ENC_STEP);  // [R12]
			srcAct[17+s]  = periphIrq.serial2[3-s];
		end
		srcLvl[21]  = fieldOf(priorityRegB_r, `ISPM_FLD_HI);                 // [R13]
		srcCode[21] = `ISPM_EV_WDOG;                                         // [R13]
		srcAct[21]  = periphIrq.watchdogInterval;
	end

	// ************************************************************
	// Priority resolution
	// ************************************************************
	always_comb begin
		coreReq_nxt = '0;
		for (int i = 0; i < NSRC; i++) begin
			// Strictly greater only, so earlier entries keep ties
			if (srcAct[i] && (srcLvl[i] != 4'h0) && (srcLvl[i] > coreReq_nxt.level)) begin // [R16] [R15]
				coreReq_nxt.valid = 1'b1;
				coreReq_nxt.level = srcLvl[i];
				coreReq_nxt.code  = srcCode[i];
			end
		end
	end

	// Registered so the core sees a clean copy; one cycle behind the sources
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			coreReq_r <= '0;
		end else begin
			coreReq_r <= coreReq_nxt;                                        // [R18]
		end
	end

	// ************************************************************
	// Acceptance and event code register
	// ************************************************************
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			eventCodeRegister_r <= 12'h000;
		end else if (coreAck && coreReq_r.valid) begin
			eventCodeRegister_r <= coreReq_r.code;                           // [R14]
		end
	end

	// ************************************************************
	// AXI4-Lite slave
	// ************************************************************
	assign doWrite = !awReady_r && !wReady_r && !bValid_r;
	assign wrHit   = (awAddr_r[1:0] == 2'b00) && (awAddr_r <= `ISPM_OFS_MASK);
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			awReady_r <= 1'b1;
			awAddr_r  <= 8'h00;
			wReady_r  <= 1'b1;
			wData_r   <= 32'h0000_0000;
			wStrb_r   <= 4'h0;
			bValid_r  <= 1'b0;
			bResp_r   <= 2'b00;
		end else begin
			if (s_axi_awvalid && awReady_r) begin
				awReady_r <= 1'b0;
				awAddr_r  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && wReady_r) begin
				wReady_r <= 1'b0;
				wData_r  <= s_axi_wdata;
				wStrb_r  <= s_axi_wstrb;
			end
			if (doWrite) begin
				awReady_r <= 1'b1;
				wReady_r  <= 1'b1;
				bValid_r <= 1'b1;
				bResp_r  <= wrHit ? 2'b00 : 2'b10;
			end else if (bValid_r && s_axi_bready) begin
				bValid_r <= 1'b0;
			end
		end
	end

	// Byte lanes: only the low two carry the 16-bit registers
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			priorityRegA_r  <= `ISPM_RST_PRIO_ABC;
			priorityRegB_r  <= `ISPM_RST_PRIO_ABC;
			priorityRegC_r  <= `ISPM_RST_PRIO_ABC;
			priorityRegD_r  <= `ISPM_RST_PRIO_D;
			pinModeSelect_r <= 1'b0;
			mask_r          <= 2'b00;
		end else if (doWrite) begin
			for (int b = 0; b < 2; b++) begin
				if (wStrb_r[b]) begin
					case (awAddr_r)
						`ISPM_OFS_PRIO_A: priorityRegA_r[b*8 +: 8] <= wData_r[b*8 +: 8] & 8'(`ISPM_WMASK_A >> (b*8));
						`ISPM_OFS_PRIO_B: priorityRegB_r[b*8 +: 8] <= wData_r[b*8 +: 8] & 8'(`ISPM_WMASK_B >> (b*8));
						`ISPM_OFS_PRIO_C: priorityRegC_r[b*8 +: 8] <= wData_r[b*8 +: 8] & 8'(`ISPM_WMASK_C >> (b*8));
						`ISPM_OFS_PRIO_D: priorityRegD_r[b*8 +: 8] <= wData_r[b*8 +: 8];
						default: ;
					endcase
				end
			end
			if (wStrb_r[0] && awAddr_r == `ISPM_OFS_CTRL) begin
				pinModeSelect_r <= wData_r[`ISPM_PINMODE_BIT];                // [R17]
			end
			if (wStrb_r[0] && awAddr_r == `ISPM_OFS_MASK) begin
				mask_r <= wData_r[1:0];
			end
		end
	end

	// Sticky status: a new event in the clearing cycle survives the clear
	always_comb begin
		statusSet                    = 2'b00;
		statusSet[`ISPM_ST_ACCEPT]   = coreAck && coreReq_r.valid;
		statusSet[`ISPM_ST_SPURIOUS] = coreAck && !coreReq_r.valid;
	end
	assign statusClr = (doWrite && wStrb_r[0] && awAddr_r == `ISPM_OFS_STATUS) ? wData_r[1:0] : 2'b00;
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			status_r <= 2'b00;
		end else begin
			status_r <= (status_r & ~statusClr) | statusSet;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			irqOut_r <= 1'b0;
		end else begin
			irqOut_r <= |(status_r & mask_r);
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rValid_r  <= 1'b0;
			arReady_r <= 1'b1;
			rData_r   <= 32'h0000_0000;
			rResp_r   <= 2'b00;
		end else if (s_axi_arvalid && arReady_r) begin
			rValid_r  <= 1'b1;
			arReady_r <= 1'b0;
			rResp_r  <= 2'b00;
			case (s_axi_araddr)
				`ISPM_OFS_PRIO_A: rData_r <= {16'h0000, priorityRegA_r};
				`ISPM_OFS_PRIO_B: rData_r <= {16'h0000, priorityRegB_r};
				`ISPM_OFS_PRIO_C: rData_r <= {16'h0000, priorityRegC_r};
				`ISPM_OFS_PRIO_D: rData_r <= {16'h0000, priorityRegD_r};
				`ISPM_OFS_CTRL:   rData_r <= {24'h00_0000, pinModeSelect_r, 7'h00};
				`ISPM_OFS_EVCODE: rData_r <= {20'h0_0000, eventCodeRegister_r}; // [R14]
				`ISPM_OFS_STATUS: rData_r <= {30'h0000_0000, status_r};
				`ISPM_OFS_MASK:   rData_r <= {30'h0000_0000, mask_r};
				default: begin
					rData_r <= 32'h0000_0000;
					rResp_r <= 2'b10;
				end
			endcase
		end else if (rValid_r && s_axi_rready) begin
			rValid_r  <= 1'b0;
			arReady_r <= 1'b1;
		end
	end

	assign s_axi_awready = awReady_r;
	assign s_axi_wready  = wReady_r;
	assign s_axi_bvalid  = bValid_r;
	assign s_axi_bresp   = bResp_r;
	assign s_axi_arready = arReady_r;
	assign s_axi_rvalid  = rValid_r;
	assign s_axi_rdata   = rData_r;
	assign s_axi_rresp   = rResp_r;
	assign coreReq       = coreReq_r;
	assign irqOut        = irqOut_r;

	// ************************************************************
	// Checks
	// ************************************************************
	AST_ENC_LEVEL5: assert property (@(posedge sys_clk) disable iff (!reset_n) // [R01]
		coreReq_r.valid && coreReq_r.code == 12'h340 |-> coreReq_r.level == 4'h5 && !$past(pinModeSelect_r))
		else $error("Encoded level 5 code with wrong level or mode");
	AST_PIN0_LEVEL: assert property (@(posedge sys_clk) disable iff (!reset_n) // [R02]
		coreReq_r.valid && coreReq_r.code == 12'h240 && $past(pinModeSelect_r)
		|-> coreReq_r.level == $past(priorityRegD_r[15:12]))
		else $error("Pin 0 level not from register D");
	AST_DEBUG_LEVEL: assert property (@(posedge sys_clk) disable iff (!reset_n) // [R06]
		coreReq_r.valid && coreReq_r.code == 12'h600 |-> coreReq_r.level == $past(priorityRegC_r[3:0]))
		else $error("Debug level not from register C");
	AST_TMR0_LEVEL: assert property (@(posedge sys_clk) disable iff (!reset_n) // [R07]
		coreReq_r.valid && coreReq_r.code == 12'h400 |-> coreReq_r.level == $past(priorityRegA_r[15:12]))
		else $error("Timer 0 level not from register A");
	AST_TMR2_RANK: assert property (@(posedge sys_clk) disable iff (!reset_n) // [R09]
		coreReq_r.valid && coreReq_r.code == 12'h460 |-> !$past(periphIrq.timer2Unf))
		else $error("Capture chosen over pending underflow");
	AST_ZERO_MASKS: assert property (@(posedge sys_clk) disable iff (!reset_n) // [R16]
		coreReq_r.valid |-> coreReq_r.level != 4'h0)
		else $error("Level zero request forwarded");
	AST_EVCODE: assert property (@(posedge sys_clk) disable iff (!reset_n) // [R14]
		coreAck && coreReq_r.valid |=> eventCodeRegister_r == $past(coreReq_r.code))
		else $error("Event code not captured on acceptance");
	AST_WDOG_ONLY: assert property (@(posedge sys_clk) disable iff (!reset_n) // [R18]
		$past(srcAct) == 22'h20_0000 && $past(priorityRegB_r[15:12]) != 4'h0
		|-> coreReq_r.valid && coreReq_r.code == 12'h560) // [R13]
		else $error("Lone watchdog request not forwarded");
endmodule

//--- ispm_core_model.sv
/*
 * Behavioural model of the core that takes requests from the priority map.
 * Assumes it shares sys_clk and reset_n with the map; acks only when enabled.
 */
`timescale 1ns/1ns
module ispm_core_model
	import ispm_pkg::*;
(
	input  wire logic            sys_clk,
	input  wire logic            reset_n,
	input  wire ispm_pkg::ispm_req_t coreReq,
	input  wire logic            ackEn,
	input  wire logic [3:0]      ackDelay,
	output logic                 coreAck
);
	import ispm_pkg::*;

	logic [3:0] waitCnt_r;

	// ************************************************************
	// Acceptance
	// ************************************************************
	// A slow core waits ackDelay cycles; the gap keeps a held source from being acked back to back
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			waitCnt_r <= 4'h0;
			coreAck   <= 1'b0;
		end else begin
			coreAck <= 1'b0;
			if (ackEn && coreReq.valid && !coreAck) begin
				if (waitCnt_r == ackDelay) begin
					coreAck   <= 1'b1;
					waitCnt_r <= 4'h0;
				end else begin
					waitCnt_r <= waitCnt_r + 4'h1;
				end
			end else begin
				waitCnt_r <= 4'h0;
			end
		end
	end
endmodule

//--- ispm_core_bench.sv
/*
 * Self-checking bench of the interrupt source priority map.
 * Assumes the core model file and the design are compiled before it.
 */
`timescale 1ns/1ns
module ispm_core_bench
	import ispm_pkg::*;
;
	logic         sys_clk, reset_n, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
	logic [7:0]   awaddr, araddr;
	logic [31:0]  wdata, rdata;
	logic [3:0]   wstrb, levelRequestPins;
	logic [1:0]   bresp, rresp;
	logic [16:0]  pv;
	ispm_periph_t periphIrq;
	ispm_req_t    coreReq;
	logic         coreAck, irqOut, ackEn;
	logic [31:0]  d;
	logic [1:0]   r;
	int           fails, nTests, cyc;
	logic [11:0]  evCode [0:16] = '{12'h560, 12'h760, 12'h740, 12'h720, 12'h700, 12'h540, 12'h520, 12'h500,
		12'h4E0, 12'h4C0, 12'h4A0, 12'h480, 12'h460, 12'h440, 12'h420, 12'h400, 12'h600};
	logic [3:0]   evLvl [0:16] = '{4'h5, 4'h8, 4'h8, 4'h8, 4'h8, 4'h6, 4'h6, 4'h6, 4'h6, 4'h1, 4'h1, 4'h1,
		4'h2, 4'h2, 4'h3, 4'h4, 4'h7};
	logic [11:0]  pinCode [0:3] = '{12'h240, 12'h2A0, 12'h300, 12'h360};
	logic [3:0]   pinLvl [0:3] = '{4'hD, 4'hA, 4'h7, 4'h4};

	ispm_core u_ispm_core (.sys_clk(sys_clk), .reset_n(reset_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .levelRequestPins(levelRequestPins),
		.periphIrq(periphIrq), .coreAck(coreAck), .coreReq(coreReq), .irqOut(irqOut));
	ispm_core_model u_ispm_core_model (.sys_clk(sys_clk), .reset_n(reset_n), .coreReq(coreReq), .ackEn(ackEn),
		.ackDelay(4'h3), .coreAck(coreAck));

	// ************************************************************
	// Clock, timeout and common tasks
	// ************************************************************
	always #4 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			give_verdict();
		end
	end
	task automatic give_verdict();
		if (fails == 0 && nTests > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		nTests++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic axiWr(input logic [7:0] a, input logic [15:0] v, output logic [1:0] rs);
		logic aw, w;
		aw = 0;
		w = 0;
		@(posedge sys_clk);
		awaddr <= a; awvalid <= 1'b1; wdata <= {16'h0000, v}; wstrb <= 4'h3; wvalid <= 1'b1; bready <= 1'b1;
		while (!(aw && w)) begin
			@(posedge sys_clk);
			if (!aw && awready) begin aw = 1; awvalid <= 1'b0; end
			if (!w && wready) begin w = 1; wvalid <= 1'b0; end
		end
		do @(posedge sys_clk); while (!bvalid);
		rs = bresp;
		bready <= 1'b0;
	endtask
	task automatic axiRd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		@(posedge sys_clk);
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		do @(posedge sys_clk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge sys_clk); while (!rvalid);
		v = rdata;
		rs = rresp;
		rready <= 1'b0;
	endtask
	task automatic setPv(input logic [16:0] v, input int n);
		@(posedge sys_clk);
		periphIrq <= v;
		tick(n);
	endtask

	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic scnRegs();
		axiRd(8'h0C, d, r); chk("prioD reset", d, 32'h0000_DA74);
		axiRd(8'h00, d, r); chk("prioA reset", d, 32'h0000_0000);
		axiWr(8'h04, 16'hFFFF, r); axiRd(8'h04, d, r); chk("prioB reserved", d, 32'h0000_F0F0);
		axiWr(8'h08, 16'hFFFF, r); axiRd(8'h08, d, r); chk("prioC reserved", d, 32'h0000_00FF);
		axiRd(8'h40, d, r); chk("unmapped resp", r, 32'h0000_0002);
		chk("unmapped data", d, 32'h0000_0000);
		axiWr(8'h40, 16'h1234, r); chk("unmapped wresp", r, 32'h0000_0002);
		axiWr(8'h1C, 16'h0000, r); chk("mapped wresp", r, 32'h0000_0000);
	endtask
	task automatic scnPins();
		axiWr(8'h10, 16'h0080, r);
		for (int i = 0; i < 4; i++) begin
			@(posedge sys_clk); levelRequestPins <= 4'(1 << i); tick(5);
			chk("pin alone", coreReq, {15'h0000, 1'b1, pinLvl[i], pinCode[i]});
		end
		@(posedge sys_clk); levelRequestPins <= 4'hF; tick(5);
		chk("pins all", coreReq, {15'h0000, 1'b1, 4'hD, 12'h240});
		axiWr(8'h10, 16'h0000, r);
		for (int k = 0; k < 6; k++) begin
			@(posedge sys_clk); levelRequestPins <= 4'h6 - 4'(k); tick(5);
			chk("encoded", coreReq, {15'h0000, 1'b1, 4'h6 - 4'(k), 12'h200 + 12'h020 * (12'h009 + 12'(k))});
		end
		@(posedge sys_clk); levelRequestPins <= 4'h0; tick(5);
		chk("pins idle", coreReq.valid, 32'h0000_0000);
	endtask
	task automatic scnPeriph();
		axiWr(8'h00, 16'h4321, r); axiWr(8'h04, 16'h5060, r); axiWr(8'h08, 16'h0087, r);
		for (int i = 0; i < 17; i++) begin
			setPv(17'(1) << i, 2);
			chk("source alone", coreReq, {15'h0000, 1'b1, evLvl[i], evCode[i]});
		end
		setPv(17'h1FFFF, 2); chk("highest level", coreReq, {15'h0000, 1'b1, 4'h8, 12'h700});
		axiWr(8'h00, 16'h5555, r); axiWr(8'h04, 16'h5050, r); axiWr(8'h08, 16'h0055, r);
		pv = 17'h1FFFF;
		for (int i = 16; i >= 0; i--) begin
			setPv(pv, 2);
			chk("tie rank", coreReq, {15'h0000, 1'b1, 4'h5, evCode[i]});
			pv[i] = 1'b0;
		end
		setPv(17'h00000, 2); chk("none pending", coreReq.valid, 32'h0000_0000);
	endtask
	task automatic scnAck();
		axiWr(8'h00, 16'h0000, r); setPv(17'h08000, 2);
		chk("field zero", coreReq.valid, 32'h0000_0000);
		axiWr(8'h00, 16'hF000, r); tick(2);
		chk("field top", coreReq, {15'h0000, 1'b1, 4'hF, 12'h400});
		axiWr(8'h1C, 16'h0001, r); axiRd(8'h1C, d, r); chk("mask", d, 32'h0000_0001);
		@(posedge sys_clk); ackEn <= 1'b1; tick(8);
		@(posedge sys_clk); ackEn <= 1'b0; periphIrq <= 17'h00000; tick(2);
		axiRd(8'h14, d, r); chk("event code", d, 32'h0000_0400);
		axiRd(8'h18, d, r); chk("accepted", d, 32'h0000_0001);
		chk("irq raised", irqOut, 32'h0000_0001);
		axiWr(8'h18, 16'h0001, r); tick(3);
		chk("irq cleared", irqOut, 32'h0000_0000);
		axiRd(8'h18, d, r); chk("status cleared", d, 32'h0000_0000);
	endtask

	initial begin
		sys_clk = 0; reset_n = 0; fails = 0; nTests = 0; cyc = 0; ackEn = 0;
		awaddr = 0; awvalid = 0; wdata = 0; wstrb = 0; wvalid = 0; bready = 0;
		araddr = 0; arvalid = 0; rready = 0; levelRequestPins = 0; periphIrq = 0;
		repeat (5) @(posedge sys_clk);
		reset_n <= 1'b1;
		scnRegs();
		scnPins();
		scnPeriph();
		scnAck();
		give_verdict();
	end
endmodule
